/* File: hdl/flash_host_pkg.sv */
// Purpose: shared constants and types for the parallel flash command host
// Assumes: mclk at 100 MHz, x16 flash on an asynchronous bus
// Notes: the device side keeps its own lockout and decode; the host sequences pins and refuses all but read and reset while the time-limit flag is up
// Notes on behaviour
// - write only when chip select and write strobe low, output gate high
// - multi-cycle commands open with AA at 555 then 55 at 2AA
// - program is unlock pair, A0 at 555, then data at target
// - chip erase is unlock, 80, unlock, then 10 at 555
// - block erase is the five-write prefix then 50 at block address
// - sector erase is the five-write prefix then 30 at sector address
// - after time-limit flag the host must write reset to resume reads
// - host must write reset to leave identifier read mode
package flash_host_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;

    typedef enum logic [3:0] {
        OP_READ, OP_RESET, OP_AUTOSEL, OP_PROGRAM, OP_CHIP_ERASE,
        OP_BLOCK_ERASE, OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_CFI
    } op_t;

    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_t;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bus_req_t;

    // command values
    localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00AA;
    localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
    localparam logic [DATA_W-1:0] CMD_AUTOSEL = 16'h0090;
    localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
    localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
    localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
    localparam logic [DATA_W-1:0] CMD_BLOCK_ERASE = 16'h0050;
    localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00B0;
    localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_CFI = 16'h0098;

    // command addresses, word and byte mode
    localparam logic [ADDR_W-1:0] WORD_UNLOCK1 = 20'h0_0555;
    localparam logic [ADDR_W-1:0] WORD_UNLOCK2 = 20'h0_02AA;
    localparam logic [ADDR_W-1:0] BYTE_UNLOCK1 = 20'h0_0AAA;
    localparam logic [ADDR_W-1:0] BYTE_UNLOCK2 = 20'h0_0555;
    localparam logic [ADDR_W-1:0] WORD_CFI = 20'h0_0055;
    localparam logic [ADDR_W-1:0] BYTE_CFI = 20'h0_00AA;

    // status bit positions in read data
    localparam int TIME_LIMIT_BIT = 5;
    localparam int TOGGLE_BIT = 6;

    // last step index of each command shape
    localparam logic [2:0] LAST_SINGLE = 3'h0;
    localparam logic [2:0] LAST_AUTOSEL = 3'h2;
    localparam logic [2:0] LAST_PROGRAM = 3'h3;
    localparam logic [2:0] LAST_ERASE = 3'h5;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_GLITCH_NS = 5;
    localparam int T_SETUP_NS = 10;
    localparam int T_WP_NS = 35;
    localparam int T_ACC_NS = 80;
    localparam int T_RECOVER_NS = 20;
    localparam int T_SUSPEND_US = 20;
    localparam int SYNC_LAT = 2;
    localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] ACC_CYC =
        4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT);
    localparam logic [3:0] RECOVER_CYC =
        4'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] GLITCH_CYC =
        4'((T_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] SUSPEND_CYC =
        12'((T_SUSPEND_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : flash_host_pkg

/* File: hdl/bus_cycle.sv */
// Purpose: one asynchronous read or write cycle on the flash pins
// Assumes: requests only while idle; dq_in is asynchronous to mclk
// Notes: chip select and strobes rise together, ending the cycle cleanly
`timescale 1ns/1ps
module bus_cycle (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // request and answer
    input wire logic req_valid,
    input wire flash_host_pkg::bus_req_t req,
    output logic done_q,
    output logic [15:0] rd_data_q,
    // flash pins
    output logic ce_n_q,
    output logic we_n_q,
    output logic oe_n_q,
    output logic [19:0] addr_q,
    output logic [15:0] dq_out_q,
    output logic dq_oe_q,
    input wire logic [15:0] dq_in
);
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} cyc_state_t;
    cyc_state_t state_q;
    logic [3:0] cnt_q;
    logic write_q;
    logic [15:0] dq_meta_q;
    logic [15:0] dq_sync_q;
    wire cnt_zero = (cnt_q == 4'h0);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dq_meta_q <= 16'h0000;
            dq_sync_q <= 16'h0000;
        end else begin
            dq_meta_q <= dq_in;
            dq_sync_q <= dq_meta_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            write_q <= 1'b0;
            done_q <= 1'b0;
            rd_data_q <= 16'h0000;
            ce_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            addr_q <= 20'h0_0000;
            dq_out_q <= 16'h0000;
            dq_oe_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        write_q <= req.write;
                        addr_q <= req.addr;
                        dq_out_q <= req.data;
                        dq_oe_q <= req.write;
                        ce_n_q <= 1'b0;
                        cnt_q <= flash_host_pkg::SETUP_CYC - 4'h1;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_zero) begin
                        we_n_q <= !write_q;
                        oe_n_q <= write_q;
                        cnt_q <= write_q ? flash_host_pkg::WP_CYC - 4'h1
                                         : flash_host_pkg::ACC_CYC - 4'h1;
                        state_q <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_zero) begin
                        we_n_q <= 1'b1;
                        oe_n_q <= 1'b1;
                        ce_n_q <= 1'b1;
                        if (!write_q) begin
                            rd_data_q <= dq_sync_q;
                        end
                        cnt_q <= flash_host_pkg::RECOVER_CYC - 4'h1;
                        state_q <= ST_RECOVER;
                    end
                end
                ST_RECOVER: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_zero) begin
                        dq_oe_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // no write strobe without chip select
    we_needs_ce_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !we_n_q |-> (!ce_n_q && oe_n_q && dq_oe_q))
        else $error("write strobe low without chip select or with output gate");

    no_all_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !(!we_n_q && !oe_n_q))
        else $error("write strobe and output gate low together");

    // write pulse far above glitch width
    write_pulse_width_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(we_n_q) |-> !we_n_q[*4] ##1 we_n_q)
        else $error("write pulse not exactly four cycles");
endmodule : bus_cycle

/* File: hdl/flash_host.sv */
// Purpose: host sequencer issuing flash command sequences over the parallel pins
// Assumes: one command at a time; user polls status with read commands
// Notes: while the time-limit flag is up only read and reset are accepted
`timescale 1ns/1ps
module flash_host #(
    parameter bit BYTE_MODE = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // command port
    input wire logic cmd_valid,
    input wire flash_host_pkg::cmd_t cmd,
    output logic cmd_ready_q,
    output logic cmd_refused_q,
    // answer port
    output logic rsp_valid_q,
    output logic [15:0] rsp_data_q,
    // status
    output logic op_busy_q,
    output logic time_limit_q,
    output logic id_mode_q,
    output logic suspend_mode_q,
    // flash pins
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic [19:0] addr,
    output logic [15:0] dq_out,
    output logic dq_oe,
    input wire logic [15:0] dq_in
);
    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_HOLDOFF} seq_state_t;
    seq_state_t state_q;
    flash_host_pkg::cmd_t cmd_q;
    flash_host_pkg::bus_req_t req_q;
    logic req_valid_q;
    logic [2:0] step_q;
    logic [11:0] hold_q;
    logic have_last_q;
    logic last_toggle_q;
    logic last_limit_q;
    logic done;
    logic [15:0] rd_data;

    localparam logic [19:0] UL1 =
        BYTE_MODE ? flash_host_pkg::BYTE_UNLOCK1 : flash_host_pkg::WORD_UNLOCK1;
    localparam logic [19:0] UL2 =
        BYTE_MODE ? flash_host_pkg::BYTE_UNLOCK2 : flash_host_pkg::WORD_UNLOCK2;
    localparam logic [19:0] CFI_A =
        BYTE_MODE ? flash_host_pkg::BYTE_CFI : flash_host_pkg::WORD_CFI;

    function automatic flash_host_pkg::bus_req_t step_req(input flash_host_pkg::cmd_t c,
                                                          input logic [2:0] s);
        flash_host_pkg::bus_req_t r;
        r.write = 1'b1;
        r.addr = c.addr;
        r.data = c.data;
        case (c.op)
            flash_host_pkg::OP_READ: r.write = 1'b0;
            flash_host_pkg::OP_RESET: r.data = flash_host_pkg::CMD_RESET;
            flash_host_pkg::OP_SUSPEND: r.data = flash_host_pkg::CMD_SUSPEND;
            flash_host_pkg::OP_RESUME: r.data = flash_host_pkg::CMD_RESUME;
            flash_host_pkg::OP_CFI: begin
                r.addr = CFI_A;
                r.data = flash_host_pkg::CMD_CFI;
            end
            default: begin
                case (s)
                    3'h0, 3'h3: begin
                        r.addr = UL1;
                        r.data = flash_host_pkg::CMD_UNLOCK1;
                    end
                    3'h1, 3'h4: begin
                        r.addr = UL2;
                        r.data = flash_host_pkg::CMD_UNLOCK2;
                    end
                    3'h2: begin
                        r.addr = UL1;
                        r.data = (c.op == flash_host_pkg::OP_AUTOSEL) ? flash_host_pkg::CMD_AUTOSEL :
                                 (c.op == flash_host_pkg::OP_PROGRAM) ? flash_host_pkg::CMD_PROGRAM :
                                 flash_host_pkg::CMD_ERASE_SETUP;
                    end
                    default: begin
                        r.data = (c.op == flash_host_pkg::OP_BLOCK_ERASE) ?
                                 flash_host_pkg::CMD_BLOCK_ERASE :
                                 flash_host_pkg::CMD_SECTOR_ERASE;
                        if (c.op == flash_host_pkg::OP_CHIP_ERASE) begin
                            r.addr = UL1;
                            r.data = flash_host_pkg::CMD_CHIP_ERASE;
                        end
                    end
                endcase
                // program target write replaces the second unlock opening
                if (c.op == flash_host_pkg::OP_PROGRAM && s == 3'h3) begin
                    r.addr = c.addr;
                    r.data = c.data;
                end
            end
        endcase
        return r;
    endfunction : step_req

    // decode of the held command
    wire is_erase = (cmd_q.op == flash_host_pkg::OP_CHIP_ERASE) ||
                    (cmd_q.op == flash_host_pkg::OP_BLOCK_ERASE) ||
                    (cmd_q.op == flash_host_pkg::OP_SECTOR_ERASE);
    wire is_multi = is_erase || (cmd_q.op == flash_host_pkg::OP_PROGRAM) ||
                    (cmd_q.op == flash_host_pkg::OP_AUTOSEL);
    wire [2:0] last_step = is_erase ? flash_host_pkg::LAST_ERASE :
                           (cmd_q.op == flash_host_pkg::OP_PROGRAM) ? flash_host_pkg::LAST_PROGRAM :
                           (cmd_q.op == flash_host_pkg::OP_AUTOSEL) ? flash_host_pkg::LAST_AUTOSEL :
                           flash_host_pkg::LAST_SINGLE;
    wire flash_host_pkg::bus_req_t next_req = step_req(cmd_q, step_q);
    wire take = cmd_valid && cmd_ready_q;
    // only read and reset while time limit is up
    wire refuse = time_limit_q && (cmd.op != flash_host_pkg::OP_RESET) &&
                  (cmd.op != flash_host_pkg::OP_READ);
    wire finish = (state_q == S_WAIT) && done && (step_q == last_step);
    wire fin_read = finish && (cmd_q.op == flash_host_pkg::OP_READ);
    wire fin_reset = finish && (cmd_q.op == flash_host_pkg::OP_RESET);
    wire starts_op = finish && (is_erase || cmd_q.op == flash_host_pkg::OP_PROGRAM ||
                                cmd_q.op == flash_host_pkg::OP_RESUME);
    wire toggle_stopped = have_last_q && (rd_data[flash_host_pkg::TOGGLE_BIT] == last_toggle_q);
    // the first array word after completion may show bit 5 high, so the flag
    // needs it on two toggling reads in a row
    wire limit_seen = have_last_q && !toggle_stopped && last_limit_q &&
                      rd_data[flash_host_pkg::TIME_LIMIT_BIT];
    wire hold_zero = (hold_q == 12'h000);

    bus_cycle u_cycle (
        .mclk(mclk),
        .rst_n(rst_n),
        .req_valid(req_valid_q),
        .req(req_q),
        .done_q(done),
        .rd_data_q(rd_data),
        .ce_n_q(ce_n),
        .we_n_q(we_n),
        .oe_n_q(oe_n),
        .addr_q(addr),
        .dq_out_q(dq_out),
        .dq_oe_q(dq_oe),
        .dq_in(dq_in)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            cmd_q <= '0;
            req_q <= '0;
            req_valid_q <= 1'b0;
            step_q <= 3'h0;
            hold_q <= 12'h000;
            cmd_ready_q <= 1'b1;
            cmd_refused_q <= 1'b0;
        end else begin
            req_valid_q <= 1'b0;
            cmd_refused_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (take && refuse) begin
                        cmd_refused_q <= 1'b1;
                    end else if (take) begin
                        cmd_q <= cmd;
                        step_q <= 3'h0;
                        cmd_ready_q <= 1'b0;
                        state_q <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    req_q <= next_req;
                    req_valid_q <= 1'b1;
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (done && step_q != last_step) begin
                        step_q <= step_q + 3'h1;
                        state_q <= S_ISSUE;
                    end else if (finish && cmd_q.op == flash_host_pkg::OP_SUSPEND) begin
                        // allow the device its suspend time
                        hold_q <= flash_host_pkg::SUSPEND_CYC;
                        state_q <= S_HOLDOFF;
                    end else if (finish) begin
                        cmd_ready_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                S_HOLDOFF: begin
                    hold_q <= hold_q - 12'h001;
                    if (hold_zero) begin
                        cmd_ready_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 16'h0000;
        end else begin
            rsp_valid_q <= fin_read;
            if (fin_read) begin
                rsp_data_q <= rd_data;
            end
        end
    end

    // toggle polling; a stopped toggle means the embedded operation ended
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            op_busy_q <= 1'b0;
            have_last_q <= 1'b0;
            last_toggle_q <= 1'b0;
            last_limit_q <= 1'b0;
            time_limit_q <= 1'b0;
        end else begin
            if (starts_op) begin
                op_busy_q <= 1'b1;
                have_last_q <= 1'b0;
            end else if (fin_read && op_busy_q) begin
                have_last_q <= !toggle_stopped;
                last_toggle_q <= rd_data[flash_host_pkg::TOGGLE_BIT];
                last_limit_q <= rd_data[flash_host_pkg::TIME_LIMIT_BIT];
                op_busy_q <= !toggle_stopped;
            end else if (fin_reset && time_limit_q) begin
                op_busy_q <= 1'b0;
                have_last_q <= 1'b0;
            end
            if (fin_read && op_busy_q && limit_seen) begin
                time_limit_q <= 1'b1;
            end else if (fin_reset) begin
                time_limit_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            id_mode_q <= 1'b0;
            suspend_mode_q <= 1'b0;
        end else begin
            // identifier or query mode left only by reset
            if (finish && (cmd_q.op == flash_host_pkg::OP_AUTOSEL ||
                           cmd_q.op == flash_host_pkg::OP_CFI)) begin
                id_mode_q <= 1'b1;
            end else if (fin_reset) begin
                id_mode_q <= 1'b0;
            end
            if (finish && cmd_q.op == flash_host_pkg::OP_SUSPEND) begin
                suspend_mode_q <= 1'b1;
            end else if (finish && cmd_q.op == flash_host_pkg::OP_RESUME) begin
                suspend_mode_q <= 1'b0;
            end
        end
    end

    first_unlock_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req_valid_q && is_multi && step_q == 3'h0) |->
        (req_q.addr == UL1 && req_q.data == 16'h00AA && req_q.write))
        else $error("first unlock write wrong");

    second_unlock_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req_valid_q && is_multi && step_q == 3'h1) |->
        (req_q.addr == UL2 && req_q.data == 16'h0055))
        else $error("second unlock write wrong");

    program_setup_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req_valid_q && cmd_q.op == flash_host_pkg::OP_PROGRAM && step_q == 3'h3) |->
        (req_q.addr == cmd_q.addr && req_q.data == cmd_q.data && $past(step_q, 2) == 3'h2))
        else $error("program data write not fourth");

    chip_erase_last_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req_valid_q && cmd_q.op == flash_host_pkg::OP_CHIP_ERASE && step_q == 3'h5) |->
        (req_q.addr == UL1 && req_q.data == 16'h0010))
        else $error("chip erase final write wrong");

    block_erase_last_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req_valid_q && cmd_q.op == flash_host_pkg::OP_BLOCK_ERASE && step_q == 3'h5) |->
        (req_q.addr[19:15] == cmd_q.addr[19:15] && req_q.data == 16'h0050))
        else $error("block erase final write wrong");

    sector_erase_last_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req_valid_q && cmd_q.op == flash_host_pkg::OP_SECTOR_ERASE && step_q == 3'h5) |->
        (req_q.addr[19:11] == cmd_q.addr[19:11] && req_q.data == 16'h0030))
        else $error("sector erase final write wrong");

    limit_refuse_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (cmd_valid && cmd_ready_q && time_limit_q && state_q == S_IDLE &&
         cmd.op == flash_host_pkg::OP_PROGRAM) |=> (cmd_refused_q && state_q == S_IDLE))
        else $error("command taken while time limit flag up");

    reset_leaves_id_a: assert property (@(posedge mclk) disable iff (!rst_n)
        fin_reset |=> (!id_mode_q && !time_limit_q))
        else $error("reset did not clear identifier mode or time limit");

    suspend_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (finish && cmd_q.op == flash_host_pkg::OP_SUSPEND) |=> !cmd_ready_q [*8])
        else $error("ready returned too soon after suspend");
endmodule : flash_host

/* File: dv/flash_dev_model.sv */
// Purpose: behavioural flash device on the parallel pins
// Assumes: the bench clears wn before each command whose writes it checks
// Notes: released data shows its inverse, never a stale copy
`timescale 1ns/1ps
module flash_dev_model (
    // flash pins
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [19:0] addr,
    input wire logic [15:0] dq_out,
    output logic [15:0] dq_in
);
    logic [35:0] wlog [16];
    int wn = 0;
    int busy = 0;
    int stuck = 0;
    logic tog = 1'b0;
    realtime t_low = 0;
    // one event when either strobe ends the write, free of update order
    wire wr_act = !ce_n && !we_n && oe_n;
    initial dq_in = 16'h5555;
    always @(posedge wr_act) t_low = $realtime;
    // write taken when the first strobe rises
    always @(negedge wr_act) begin
        if ($realtime - t_low >= 5.0 && wn < 16) begin
            if (wn > 0 && (wlog[wn-1][15:0] == 16'h00a0 || (wn > 4 && dq_out != 16'h00aa)))
                busy = 4;
            if (dq_out == 16'h00f0)
                stuck = 0;
            wlog[wn] = {addr, dq_out};
            wn++;
        end
    end
    // array data on reads, toggle bit while busy
    // a stuck operation keeps toggling with the time-limit flag up
    always @(negedge oe_n) begin
        #40;
        if (busy > 0 || stuck != 0) begin
            dq_in = {9'h000, tog, stuck[0], 5'h00};
            tog = ~tog;
            if (busy > 0)
                busy--;
        end else
            dq_in = addr[15:0] ^ 16'h3c3c;
    end
    always @(posedge oe_n) #5 dq_in = ~dq_in;
endmodule : flash_dev_model

/* File: dv/flash_host_tb.sv */
// Purpose: self-checking bench for the flash command host
// Assumes: device model logs every write it accepts
// Notes: each command's write count and last write, and the second write of multi-write commands, are compared with the expected values
`timescale 1ns/1ps
module flash_host_tb;
    logic mclk = 0, rst_n = 0, cmd_valid = 0, cmd_ready_q, cmd_refused_q, rsp_valid_q;
    logic op_busy_q, time_limit_q, id_mode_q, suspend_mode_q, ce_n, we_n, oe_n, dq_oe;
    logic [15:0] rsp_data_q, dq_out, dq_in;
    logic [19:0] addr;
    flash_host_pkg::cmd_t cmd = '0;
    int err_total = 0, comparisons = 0, cyc = 0, refused = 0;
    int codes [9] = '{2, 1, 3, 4, 5, 6, 7, 8, 9};
    int cnt [9] = '{3, 1, 4, 6, 6, 6, 1, 1, 1};
    flash_host i_flash_host (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready_q(cmd_ready_q), .cmd_refused_q(cmd_refused_q), .rsp_valid_q(rsp_valid_q),
        .rsp_data_q(rsp_data_q), .op_busy_q(op_busy_q), .time_limit_q(time_limit_q),
        .id_mode_q(id_mode_q), .suspend_mode_q(suspend_mode_q), .ce_n(ce_n), .we_n(we_n),
        .oe_n(oe_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    flash_dev_model i_flash_dev_model (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
        .dq_out(dq_out), .dq_in(dq_in));
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    function automatic logic [35:0] last_wr(input int c, input logic [35:0] ad);
        case (c)
            1: return {ad[35:16], 16'h00f0};
            2: return {20'h0_0555, 16'h0090};
            3: return ad;
            4: return {20'h0_0555, 16'h0010};
            5: return {ad[35:16], 16'h0050};
            7: return {20'h0_0000, 16'h00b0};
            9: return {20'h0_0055, 16'h0098};
            default: return {ad[35:16], 16'h0030};
        endcase
    endfunction : last_wr
    task automatic issue(input int c, input logic [35:0] ad);
        @(negedge mclk);
        cmd_valid = 1;
        cmd = {flash_host_pkg::op_t'(c), ad};
        @(negedge mclk);
        cmd_valid = 0;
        repeat (3000) begin
            @(negedge mclk);
            if (cmd_ready_q === 1'b1) break;
        end
    endtask : issue
    initial forever #5 mclk = ~mclk;
    always @(negedge mclk) refused += int'(cmd_refused_q === 1'b1);
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        logic [35:0] ad;
        int n;
        void'($urandom(32'h267281f7));
        repeat (16) @(negedge mclk);
        rst_n = 1;
        for (int i = 0; i < 4; i++) begin
            ad = (i == 0) ? 36'hf_ffff_0000 : 36'($urandom) << 4;
            issue(0, ad);
            check(36'(rsp_data_q), 36'(ad[31:16] ^ 16'h3c3c));
            check(36'(rsp_valid_q), 36'h0_0000_0001);
        end
        for (int k = 0; k < 9; k++) begin
            ad = {20'($urandom), 16'($urandom)};
            i_flash_dev_model.wn = 0;
            issue(codes[k], ad);
            check(36'(i_flash_dev_model.wn), 36'(cnt[k]));
            n = (codes[k] == 7) ? 20 : 0;
            check(i_flash_dev_model.wlog[cnt[k]-1] << n, last_wr(codes[k], ad) << n);
            if (cnt[k] > 1)
                check(i_flash_dev_model.wlog[1], 36'h0_02aa_0055);
            check({id_mode_q, suspend_mode_q}, {codes[k] == 2 || codes[k] == 9,
                codes[k] == 7});
            check(36'(op_busy_q), 36'((codes[k] > 2 && codes[k] < 7) || codes[k] == 8));
            for (n = 0; n < 12 && op_busy_q !== 1'b0; n++) issue(0, ad);
            check(36'(op_busy_q), 36'h0_0000_0000);
            check(36'(dq_oe), 36'h0_0000_0000);
        end
        // stuck program: flag up, a second program refused, reset recovers
        i_flash_dev_model.wn = 0;
        i_flash_dev_model.stuck = 1;
        issue(3, ad);
        for (n = 0; n < 12 && time_limit_q !== 1'b1; n++) issue(0, ad);
        check(36'(time_limit_q), 36'h0_0000_0001);
        i_flash_dev_model.wn = 0;
        n = refused;
        issue(3, ad);
        check(36'(refused - n), 36'h0_0000_0001);
        check(36'(i_flash_dev_model.wn), 36'h0_0000_0000);
        issue(1, ad);
        check({time_limit_q, op_busy_q, i_flash_dev_model.stuck[0]}, 36'h0_0000_0000);
        finish_test();
    end
endmodule : flash_host_tb
